// File: rtl/sec_pkg.sv
package sec_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CMD  = 8'hb0;
	localparam logic [7:0] OFS_DATA = 8'hb4;
	localparam logic [7:0] OFS_IST  = 8'hb8;
	localparam logic [7:0] OFS_ICLR = 8'hbc;
	localparam logic [7:0] OFS_IEN  = 8'hc0;

	// Command register fields
	localparam int CMD_BUSY_BIT   = 31;
	localparam int CMD_OP_MSB     = 30;
	localparam int CMD_OP_LSB     = 28;
	localparam int CMD_TMO_BIT    = 9;
	localparam int CMD_LOADED_BIT = 8;
	localparam int CMD_ADDR_MSB   = 7;

	// Reset values
	localparam logic [7:0]  ADDR_RST = 8'h00;
	localparam logic [7:0]  DATA_RST = 8'h00;
	localparam logic [47:0] STA_RST  = 48'h0;

	// Interrupt status layout
	localparam int IRQ_W    = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_TMO  = 1;
	localparam int IRQ_LOAD = 2;

	// Serial frame layout
	localparam int          FRAME_W   = 19;
	localparam logic [4:0]  CMD_BITS  = 5'h0b;
	localparam logic [4:0]  WR_BITS   = 5'h13;
	localparam logic [4:0]  RD_BITS   = 5'h08;
	localparam logic [4:0]  NO_BITS   = 5'h00;
	localparam logic [1:0]  OPC_EXT   = 2'h0;
	localparam logic [1:0]  OPC_WRITE = 2'h1;
	localparam logic [1:0]  OPC_READ  = 2'h2;
	localparam logic [1:0]  OPC_ERASE = 2'h3;
	localparam logic [7:0]  EXT_EWDS  = 8'h00;
	localparam logic [7:0]  EXT_WRAL  = 8'h40;
	localparam logic [7:0]  EXT_ERAL  = 8'h80;
	localparam logic [7:0]  EXT_EWEN  = 8'hc0;

	// Station address load
	localparam logic [2:0] LOAD_LAST = 3'h6;
	localparam logic [7:0] LOAD_SIG  = 8'ha5;

	// Timing
	localparam int CLK_MHZ       = 100;
	localparam int TIMEOUT_MS    = 30;
	localparam int TIMEOUT_CYC   = TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int SCK_HALF_NS   = 500;
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int CS_GAP_NS     = 500;
	localparam int CS_GAP_CYC    = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam logic [6:0] SCK_HALF_LAST = 7'(SCK_HALF_CYC - 1);
	localparam logic [6:0] CS_GAP_LAST   = 7'(CS_GAP_CYC - 1);

	typedef enum logic [2:0]
	{
		OP_READ   = 3'h0,
		OP_EWDS   = 3'h1,
		OP_EWEN   = 3'h2,
		OP_WRITE  = 3'h3,
		OP_WRAL   = 3'h4,
		OP_ERASE  = 3'h5,
		OP_ERAL   = 3'h6,
		OP_RELOAD = 3'h7
	} sec_op_t;

	typedef struct packed
	{
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} sec_bus_t;

endpackage

// File: rtl/sec_timer.sv
module sec_timer #(
	parameter int LIMIT = 3000000
) (
	input  wire logic core_clk_in,
	input  wire logic reset_in,
	input  wire logic run_in,
	output logic      expired_out
);
	import sec_pkg::*;

	localparam int CW = $clog2(LIMIT + 1);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          exp_r;
	logic          exp_nxt;

	always_comb
	begin
		exp_nxt = run_in && (cnt_r == CW'(LIMIT - 1));
		cnt_nxt = '0;
		if (run_in)
		begin
			cnt_nxt = exp_nxt ? cnt_r : cnt_r + CW'(1);
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			cnt_r <= '0;
			exp_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign expired_out = exp_r;

endmodule

// File: rtl/sec_shifter.sv
module sec_shifter (
	input  wire logic               core_clk_in,
	input  wire logic               reset_in,
	input  wire logic               start_in,
	input  wire logic [18:0]        frame_in,
	input  wire logic [4:0]         nout_in,
	input  wire logic [4:0]         nin_in,
	input  wire logic               sdi_in,
	output logic                    sck_out,
	output logic                    sdo_out,
	output logic                    soe_out,
	output logic [7:0]              rx_out,
	output logic                    done_out
);
	import sec_pkg::*;

	typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} sec_sh_t;

	sec_sh_t            st_r, st_nxt;
	logic [FRAME_W-1:0] frm_r, frm_nxt;
	logic [4:0]         nout_r, nout_nxt;
	logic [4:0]         tot_r, tot_nxt;
	logic [4:0]         bit_r, bit_nxt;
	logic [6:0]         cnt_r, cnt_nxt;
	logic               sck_r, sck_nxt;
	logic               sdo_r, sdo_nxt;
	logic               soe_r, soe_nxt;
	logic [7:0]         rx_r, rx_nxt;
	logic               done_r, done_nxt;

	always_comb
	begin
		st_nxt   = st_r;
		frm_nxt  = frm_r;
		nout_nxt = nout_r;
		tot_nxt  = tot_r;
		bit_nxt  = bit_r;
		cnt_nxt  = cnt_r + 7'h01;
		sck_nxt  = sck_r;
		sdo_nxt  = sdo_r;
		soe_nxt  = soe_r;
		rx_nxt   = rx_r;
		done_nxt = 1'b0;
		unique case (st_r)
			SH_IDLE:
			begin
				cnt_nxt = 7'h00;
				if (start_in)
				begin
					frm_nxt  = frame_in;
					nout_nxt = nout_in;
					tot_nxt  = nout_in + nin_in;
					bit_nxt  = 5'h00;
					sdo_nxt  = frame_in[FRAME_W-1];
					soe_nxt  = nout_in != 5'h00;
					st_nxt   = SH_LOW;
				end
			end
			SH_LOW:
			begin
				if (cnt_r == SCK_HALF_LAST)
				begin
					cnt_nxt = 7'h00;
					sck_nxt = 1'b1;
					st_nxt  = SH_HIGH;
					if (bit_r >= nout_r)
					begin
						rx_nxt = {rx_r[6:0], sdi_in};
					end
				end
			end
			SH_HIGH:
			begin
				if (cnt_r == SCK_HALF_LAST)
				begin
					cnt_nxt = 7'h00;
					sck_nxt = 1'b0;
					if (bit_r == tot_r - 5'h01)
					begin
						st_nxt   = SH_IDLE;
						sdo_nxt  = 1'b0;
						soe_nxt  = 1'b0;
						done_nxt = 1'b1;
					end
					else
					begin
						frm_nxt = {frm_r[FRAME_W-2:0], 1'b0};
						sdo_nxt = frm_r[FRAME_W-2];
						soe_nxt = (bit_r + 5'h01) < nout_r;
						bit_nxt = bit_r + 5'h01;
						st_nxt  = SH_LOW;
					end
				end
			end
			default: st_nxt = SH_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			st_r   <= SH_IDLE;
			frm_r  <= '0;
			nout_r <= 5'h00;
			tot_r  <= 5'h00;
			bit_r  <= 5'h00;
			cnt_r  <= 7'h00;
			sck_r  <= 1'b0;
			sdo_r  <= 1'b0;
			soe_r  <= 1'b0;
			rx_r   <= 8'h00;
			done_r <= 1'b0;
		end
		else
		begin
			st_r   <= st_nxt;
			frm_r  <= frm_nxt;
			nout_r <= nout_nxt;
			tot_r  <= tot_nxt;
			bit_r  <= bit_nxt;
			cnt_r  <= cnt_nxt;
			sck_r  <= sck_nxt;
			sdo_r  <= sdo_nxt;
			soe_r  <= soe_nxt;
			rx_r   <= rx_nxt;
			done_r <= done_nxt;
		end
	end

	assign sck_out  = sck_r;
	assign sdo_out  = sdo_r;
	assign soe_out  = soe_r;
	assign rx_out   = rx_r;
	assign done_out = done_r;

endmodule

// File: rtl/sec_nvm_controller.sv
// Function
// - No answer within the time-out interval abandons the operation and returns idle.
// - A time-out sets the sticky time-out flag; writing one to it clears it.
// - A data pin held high with no memory completes commands without time-out.
// - In that case busy drops on the first ready check after shifting and the chip-select gap.
// - Only erase, erase-all, write and write-all wait for ready and may time out.
// - Address-loaded flag sets only after a valid memory and a normal load.
// - Address-loaded flag sets after the power-up load or a reload command.
// - Eight-bit address field, reset zero, selects the memory byte for operations.
// - Data register low byte holds the byte read or to be written; resets zero.
//
// Local design decision: the address-and-strobe port.
module sec_nvm_controller #(
	parameter int TIMEOUT_CYCLES = sec_pkg::TIMEOUT_CYC
) (
	input  wire logic              core_clk_in,
	input  wire logic              reset_in,
	input  wire sec_pkg::sec_bus_t bus_in,
	output logic [31:0]            rdata_out,
	output logic                   nvm_cs_out,
	output logic                   nvm_sck_out,
	input  wire logic              nvm_serial_io_pin_in,
	output logic                   nvm_serial_io_pin_out,
	output logic                   nvm_serial_io_pin_oe_out,
	output logic [47:0]            sta_addr_out,
	output logic                   irq_out
);
	import sec_pkg::*;
	typedef enum logic [2:0] {ST_IDLE, ST_LAUNCH, ST_SHIFT, ST_GAP, ST_WAIT} sec_st_t;

	function automatic logic is_wait_class(input sec_op_t op);
		return (op == OP_ERASE) || (op == OP_ERAL) || (op == OP_WRITE) || (op == OP_WRAL);
	endfunction
	function automatic logic [FRAME_W-1:0] build_frame(input sec_op_t op, input logic [7:0] a,
		input logic [7:0] d);
		logic [1:0] opc;
		logic [7:0] fa;
		opc = OPC_EXT;
		fa  = a;
		unique case (op)
			OP_READ, OP_RELOAD: opc = OPC_READ;
			OP_WRITE:           opc = OPC_WRITE;
			OP_ERASE:           opc = OPC_ERASE;
			OP_EWDS:            fa  = EXT_EWDS;
			OP_EWEN:            fa  = EXT_EWEN;
			OP_WRAL:            fa  = EXT_WRAL;
			OP_ERAL:            fa  = EXT_ERAL;
		endcase
		return {1'b1, opc, fa, d};
	endfunction

	sec_st_t           st_r, st_nxt;
	sec_op_t           op_r, op_nxt;
	logic              busy_r, busy_nxt;
	logic              pend_r, pend_nxt;
	logic              rel_r, rel_nxt;
	logic [2:0]        idx_r, idx_nxt;
	logic [7:0]        addr_r, addr_nxt;
	logic [7:0]        data_r, data_nxt;
	logic              tmo_r, tmo_nxt;
	logic              loaded_r, loaded_nxt;
	logic [47:0]       sta_r, sta_nxt;
	logic              cs_r, cs_nxt;
	logic [6:0]        gap_r, gap_nxt;
	logic [IRQ_W-1:0]  ist_r, ist_nxt;
	logic [IRQ_W-1:0]  ien_r, ien_nxt;
	logic              irq_r, irq_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [IRQ_W-1:0]  ev;
	logic [IRQ_W-1:0]  iclr;
	logic              cmd_wr;
	logic              sh_start;
	logic              sh_done;
	logic [7:0]        sh_rx;
	logic [4:0]        sh_nout;
	logic [4:0]        sh_nin;
	logic [7:0]        mem_addr;
	logic              tmr_run;
	logic              tmr_exp;
	sec_op_t           wr_op;

	assign cmd_wr   = bus_in.wr && (bus_in.addr == OFS_CMD);
	assign wr_op    = sec_op_t'(bus_in.wdata[CMD_OP_MSB:CMD_OP_LSB]);
	assign sh_start = st_r == ST_LAUNCH;
	assign mem_addr = rel_r ? {5'h00, idx_r} : addr_r;
	assign sh_nout  = (op_r == OP_WRITE || op_r == OP_WRAL) && !rel_r ? WR_BITS : CMD_BITS;
	assign sh_nin   = (op_r == OP_READ || rel_r) ? RD_BITS : NO_BITS;
	assign tmr_run  = st_r == ST_WAIT;

	sec_shifter u_shifter (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.start_in    (sh_start),
		.frame_in    (build_frame(op_r, mem_addr, data_r)),
		.nout_in     (sh_nout),
		.nin_in      (sh_nin),
		.sdi_in      (nvm_serial_io_pin_in),
		.sck_out     (nvm_sck_out),
		.sdo_out     (nvm_serial_io_pin_out),
		.soe_out     (nvm_serial_io_pin_oe_out),
		.rx_out      (sh_rx),
		.done_out    (sh_done)
	);

	sec_timer #(
		.LIMIT (TIMEOUT_CYCLES)
	) u_timer (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.run_in      (tmr_run),
		.expired_out (tmr_exp)
	);

	always_comb
	begin
		st_nxt     = st_r;
		op_nxt     = op_r;
		busy_nxt   = busy_r;
		pend_nxt   = pend_r;
		rel_nxt    = rel_r;
		idx_nxt    = idx_r;
		addr_nxt   = addr_r;
		data_nxt   = data_r;
		tmo_nxt    = tmo_r;
		loaded_nxt = loaded_r;
		sta_nxt    = sta_r;
		cs_nxt     = cs_r;
		gap_nxt    = 7'h00;
		ev         = '0;
		if (cmd_wr && bus_in.wdata[CMD_TMO_BIT])
		begin
			tmo_nxt = 1'b0;
		end
		if (cmd_wr && !busy_r)
		begin
			addr_nxt = bus_in.wdata[CMD_ADDR_MSB:0];
			if (bus_in.wdata[CMD_BUSY_BIT])
			begin
				op_nxt   = wr_op;
				busy_nxt = 1'b1;
				if (wr_op == OP_RELOAD)
				begin
					pend_nxt = 1'b1;
				end
				else
				begin
					st_nxt = ST_LAUNCH;
				end
			end
		end
		if (bus_in.wr && (bus_in.addr == OFS_DATA) && !busy_r)
		begin
			data_nxt = bus_in.wdata[7:0];
		end
		unique case (st_r)
			ST_IDLE:
			begin
				if (pend_r)
				begin
					pend_nxt   = 1'b0;
					rel_nxt    = 1'b1;
					idx_nxt    = 3'h0;
					loaded_nxt = 1'b0;
					st_nxt     = ST_LAUNCH;
				end
			end
			ST_LAUNCH:
			begin
				cs_nxt = 1'b1;
				st_nxt = ST_SHIFT;
			end
			ST_SHIFT:
			begin
				if (sh_done)
				begin
					cs_nxt = 1'b0;
					if (rel_r)
					begin
						if (idx_r == 3'h0 && sh_rx != LOAD_SIG)
						begin
							rel_nxt  = 1'b0;
							busy_nxt = 1'b0;
							ev[IRQ_DONE] = 1'b1;
							st_nxt   = ST_IDLE;
						end
						else
						begin
							if (idx_r != 3'h0)
							begin
								sta_nxt[8*(idx_r-3'h1) +: 8] = sh_rx;
							end
							if (idx_r == LOAD_LAST)
							begin
								loaded_nxt   = 1'b1;
								rel_nxt      = 1'b0;
								busy_nxt     = 1'b0;
								ev[IRQ_LOAD] = 1'b1;
								ev[IRQ_DONE] = 1'b1;
								st_nxt       = ST_IDLE;
							end
							else
							begin
								idx_nxt = idx_r + 3'h1;
								st_nxt  = ST_GAP;
							end
						end
					end
					else if (is_wait_class(op_r))
					begin
						st_nxt = ST_GAP;
					end
					else
					begin
						if (op_r == OP_READ)
						begin
							data_nxt = sh_rx;
						end
						busy_nxt     = 1'b0;
						ev[IRQ_DONE] = 1'b1;
						st_nxt       = ST_IDLE;
					end
				end
			end
			ST_GAP:
			begin
				gap_nxt = gap_r + 7'h01;
				if (gap_r == CS_GAP_LAST)
				begin
					gap_nxt = 7'h00;
					if (rel_r)
					begin
						st_nxt = ST_LAUNCH;
					end
					else
					begin
						cs_nxt = 1'b1;
						st_nxt = ST_WAIT;
					end
				end
			end
			ST_WAIT:
			begin
				if (nvm_serial_io_pin_in)
				begin
					cs_nxt       = 1'b0;
					busy_nxt     = 1'b0;
					ev[IRQ_DONE] = 1'b1;
					st_nxt       = ST_IDLE;
				end
				else if (tmr_exp)
				begin
					cs_nxt      = 1'b0;
					busy_nxt    = 1'b0;
					tmo_nxt     = 1'b1;
					ev[IRQ_TMO] = 1'b1;
					st_nxt      = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_comb
	begin
		iclr = '0;
		ien_nxt = ien_r;
		if (bus_in.wr && (bus_in.addr == OFS_ICLR))
		begin
			iclr = bus_in.wdata[IRQ_W-1:0];
		end
		if (bus_in.wr && (bus_in.addr == OFS_IEN))
		begin
			ien_nxt = bus_in.wdata[IRQ_W-1:0];
		end
		ist_nxt = (ist_r & ~iclr) | ev;
		irq_nxt = |(ist_r & ien_r);
		rdata_nxt = 32'h0000_0000;
		if (bus_in.rd)
		begin
			unique case (bus_in.addr)
				OFS_CMD:  rdata_nxt = {busy_r, op_r, 18'h0, tmo_r, loaded_r, addr_r};
				OFS_DATA: rdata_nxt = {24'h00_0000, data_r};
				OFS_IST:  rdata_nxt = {29'h0, ist_r};
				OFS_IEN:  rdata_nxt = {29'h0, ien_r};
				default:  rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			st_r     <= ST_IDLE;
			op_r     <= OP_RELOAD;
			busy_r   <= 1'b1;
			pend_r   <= 1'b1;
			rel_r    <= 1'b0;
			idx_r    <= 3'h0;
			addr_r   <= ADDR_RST;
			data_r   <= DATA_RST;
			tmo_r    <= 1'b0;
			loaded_r <= 1'b0;
			sta_r    <= STA_RST;
			cs_r     <= 1'b0;
			gap_r    <= 7'h00;
			ist_r    <= '0;
			ien_r    <= '0;
			irq_r    <= 1'b0;
			rdata_r  <= 32'h0000_0000;
		end
		else
		begin
			st_r     <= st_nxt;
			op_r     <= op_nxt;
			busy_r   <= busy_nxt;
			pend_r   <= pend_nxt;
			rel_r    <= rel_nxt;
			idx_r    <= idx_nxt;
			addr_r   <= addr_nxt;
			data_r   <= data_nxt;
			tmo_r    <= tmo_nxt;
			loaded_r <= loaded_nxt;
			sta_r    <= sta_nxt;
			cs_r     <= cs_nxt;
			gap_r    <= gap_nxt;
			ist_r    <= ist_nxt;
			ien_r    <= ien_nxt;
			irq_r    <= irq_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign rdata_out    = rdata_r;
	assign nvm_cs_out   = cs_r;
	assign sta_addr_out = sta_r;
	assign irq_out      = irq_r;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);
	sequence s_wait_expire;
		(st_r == ST_WAIT) && !nvm_serial_io_pin_in && tmr_exp;
	endsequence
	sequence s_tmo_report;
		tmo_r && ist_r[IRQ_TMO] ##1 irq_r == ien_r[IRQ_TMO] || irq_r;
	endsequence

	chk_timeout_idle: assert property (s_wait_expire |=> (st_r == ST_IDLE) && !busy_r && !cs_r)
		else $error("time-out did not return idle");
	chk_timeout_flag: assert property (s_wait_expire |=> s_tmo_report)
		else $error("time-out flag not set");
	chk_tmo_clear: assert property (cmd_wr && bus_in.wdata[CMD_TMO_BIT] && !((st_r == ST_WAIT) && tmr_exp) |=> !tmo_r)
		else $error("time-out flag not cleared");
	chk_high_finish: assert property ((st_r == ST_WAIT) && nvm_serial_io_pin_in |=> !busy_r && ist_r[IRQ_DONE])
		else $error("ready pin did not finish command");
	chk_shift_release: assert property ((st_r == ST_SHIFT) && sh_done && !rel_r && !is_wait_class(op_r) |=> !busy_r)
		else $error("busy held after shifting");
	chk_wait_class: assert property ($rose(st_r == ST_WAIT) |-> is_wait_class(op_r) && !rel_r)
		else $error("non-erase/write command waits for ready");
	chk_loaded_cause: assert property ($rose(loaded_r) |-> $past(rel_r && sh_done && idx_r == LOAD_LAST))
		else $error("address-loaded set without load");
	chk_loaded_drop: assert property ((st_r == ST_IDLE) && pend_r |=> !loaded_r && rel_r)
		else $error("reload did not restart load");
	chk_addr_write: assert property (cmd_wr && !busy_r |=> addr_r == $past(bus_in.wdata[7:0]))
		else $error("address field not written");
	chk_data_read: assert property (bus_in.rd && (bus_in.addr == OFS_DATA) |=> rdata_r == {24'h00_0000, $past(data_r)})
		else $error("data read-back wrong");

endmodule

// File: dv/sec_nvm_memory.sv
module sec_nvm_memory (
	input  wire logic clk_in,
	input  wire logic present_in,
	input  wire logic cs_in,
	input  wire logic sck_in,
	input  wire logic di_in,
	output logic      do_out,
	output logic      oe_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [256];
	logic [18:0] sh = '0;
	logic [10:0] hd;
	logic [7:0]  rbyte = '0;
	logic        ewen = 1'b0;
	logic        pend = 1'b0;
	logic        rdy = 1'b0;
	logic        rd_op = 1'b0;
	int          n = 0;
	int          cnt = 0;
	int          delay = 5;

	initial
	begin
		do_out = 1'b0;
		oe_out = 1'b0;
	end

	// New frame, or start of the ready answer after a program cycle
	always @(posedge cs_in)
	begin
		n = 0;
		rd_op = 1'b0;
		if (pend && present_in)
		begin
			cnt = delay;
			oe_out = 1'b1;
			do_out = 1'b0;
			rdy = 1'b1;
			pend = 1'b0;
		end
	end

	always @(posedge clk_in)
		if (rdy)
		begin
			if (cnt == 0)
				do_out = 1'b1;
			else
				cnt--;
		end

	always @(posedge sck_in)
		if (cs_in && present_in)
		begin
			sh = {sh[17:0], di_in};
			n++;
			if (n == 11 && sh[9:8] == 2'h2)
			begin
				rd_op = 1'b1;
				rbyte = mem[sh[7:0]];
			end
		end

	// Read data change on the falling clock, MSB first
	always @(negedge sck_in)
		if (rd_op && n >= 11 && n <= 18)
		begin
			oe_out = 1'b1;
			do_out = rbyte[18 - n];
		end

	// Deselect releases the line and commits a program command
	always @(negedge cs_in)
	begin
		oe_out = 1'b0;
		rdy = 1'b0;
		if (present_in && n >= 11 && !rd_op)
		begin
			hd = 11'(sh >> (n - 11));
			pend = (hd[9:8] != 2'h0) || (hd[7] ^ hd[6]);
			if (hd[9:8] == 2'h1 && ewen)
				mem[hd[7:0]] = sh[7:0];
			if (hd[9:8] == 2'h3 && ewen)
				mem[hd[7:0]] = 8'hff;
			if (hd[9:8] == 2'h0)
				case (hd[7:6])
					2'h3: ewen = 1'b1;
					2'h0: ewen = 1'b0;
					2'h1: foreach (mem[i]) if (ewen) mem[i] = sh[7:0];
					default: foreach (mem[i]) if (ewen) mem[i] = 8'hff;
				endcase
		end
	end
endmodule

// File: dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import sec_pkg::*;

	localparam int TMO = 200;
	logic        core_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	sec_bus_t    bus = '0;
	logic [31:0] rdata;
	logic        cs, sck, pin, dout, doe, mdo, moe, irq;
	logic        present = 1'b1;
	logic        pull = 1'b1;
	logic [47:0] sta;
	logic [31:0] seed = 32'h00017c69;
	logic [31:0] v;
	logic [7:0]  a, d;
	int          err_total = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n;

	assign pin = doe ? dout : (moe ? mdo : pull);

	sec_nvm_controller #(.TIMEOUT_CYCLES(TMO)) DUT (
		.core_clk_in              (core_clk_in),
		.reset_in                 (reset_in),
		.bus_in                   (bus),
		.rdata_out                (rdata),
		.nvm_cs_out               (cs),
		.nvm_sck_out              (sck),
		.nvm_serial_io_pin_in     (pin),
		.nvm_serial_io_pin_out    (dout),
		.nvm_serial_io_pin_oe_out (doe),
		.sta_addr_out             (sta),
		.irq_out                  (irq)
	);

	sec_nvm_memory MEM (
		.clk_in     (core_clk_in),
		.present_in (present),
		.cs_in      (cs),
		.sck_in     (sck),
		.di_in      (pin),
		.do_out     (mdo),
		.oe_out     (moe)
	);

	always #5 core_clk_in = ~core_clk_in;

	function automatic logic [7:0] pat(input int i);
		return (i == 0) ? 8'ha5 : 8'(i * 29 + 7);
	endfunction

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic tmo_op(input int k);
		return (k >= 3 && k <= 6);
	endfunction

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk_in);
		#1;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		@(posedge core_clk_in);
		bus <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_in);
		bus <= '0;
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
		@(posedge core_clk_in);
		bus <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_in);
		bus <= '0;
		#1;
		rv = rdata;
	endtask

	task automatic idle(output int cnt);
		cnt = 0;
		v = 32'hffffffff;
		while (v[CMD_BUSY_BIT] !== 1'b0 && cnt < 30000)
		begin
			rd(OFS_CMD, v);
			cnt += 2;
		end
		check("busy clears", v[CMD_BUSY_BIT], 1'b0);
	endtask

	task automatic cmd(input logic [2:0] op, input logic [7:0] ad);
		wr(OFS_CMD, {1'b1, op, 20'h0, ad});
		idle(n);
	endtask

	always @(posedge core_clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			err_total++;
			give_verdict();
		end
	end

	initial
	begin
		foreach (MEM.mem[i])
			MEM.mem[i] = pat(i);
		repeat (20) @(posedge core_clk_in);
		reset_in <= 1'b0;
		rd(OFS_DATA, v);
		check("data reset", v, 32'(DATA_RST));
		rd(OFS_CMD, v);
		check("address reset", v[7:0], ADDR_RST);
		idle(n);
		rd(OFS_CMD, v);
		check("loaded at power-up", v[CMD_LOADED_BIT], 1'b1);
		check("station address", sta, {pat(6), pat(5), pat(4), pat(3), pat(2), pat(1)});
		rd(OFS_IST, v);
		check("status after load", v[2:0], 3'h5);
		check("irq masked", irq, 1'b0);
		wr(OFS_IEN, 32'h4);
		wr(OFS_IST, 32'h0);
		tick(2);
		check("irq enabled", irq, 1'b1);
		rd(OFS_IST, v);
		check("status read-only", v[2:0], 3'h5);
		wr(OFS_ICLR, 32'h7);
		tick(2);
		check("irq cleared", irq, 1'b0);
		rd(OFS_IST, v);
		check("status cleared", v[2:0], 3'h0);
		rd(8'h10, v);
		check("unmapped read", v, 32'h0);
		cmd(OP_EWEN, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			a = 8'(8 + xs() % 248);
			d = 8'(xs());
			MEM.delay = (k == 3) ? 150 : 3;
			wr(OFS_DATA, {24'h0, d});
			cmd(OP_WRITE, a);
			check("memory byte written", MEM.mem[a], d);
			rd(OFS_CMD, v);
			check("no time-out on slow ready", v[CMD_TMO_BIT], 1'b0);
			cmd(OP_READ, a);
			rd(OFS_DATA, v);
			check("byte read back", v[7:0], d);
		end
		cmd(OP_ERASE, a);
		cmd(OP_READ, a);
		rd(OFS_DATA, v);
		check("erased byte", v[7:0], 8'hff);
		cmd(OP_RELOAD, 8'h00);
		rd(OFS_CMD, v);
		check("loaded after reload", v[CMD_LOADED_BIT], 1'b1);
		wr(OFS_DATA, 32'h5a);
		cmd(OP_WRAL, 8'h00);
		cmd(OP_READ, a);
		rd(OFS_DATA, v);
		check("write-all byte", v[7:0], 8'h5a);
		cmd(OP_ERAL, 8'h00);
		cmd(OP_RELOAD, 8'h00);
		rd(OFS_CMD, v);
		check("no load from blank memory", v[CMD_LOADED_BIT], 1'b0);
		@(posedge core_clk_in);
		present <= 1'b0;
		pull <= 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			cmd(3'(k), a);
			rd(OFS_CMD, v);
			check("time-out only on erase and write", v[CMD_TMO_BIT], tmo_op(k));
			check("chip select idle after command", cs, 1'b0);
			check("serial clock idle after command", sck, 1'b0);
			check("data pin released after command", doe, 1'b0);
			if (tmo_op(k))
			begin
				wr(OFS_CMD, 32'h200);
				rd(OFS_CMD, v);
				check("time-out flag cleared", v[CMD_TMO_BIT], 1'b0);
			end
		end
		@(posedge core_clk_in);
		pull <= 1'b1;
		cmd(OP_WRITE, a);
		check("busy drops once shifted", n < 2100, 1'b1);
		rd(OFS_CMD, v);
		check("no time-out with pin high", v[CMD_TMO_BIT], 1'b0);
		cmd(OP_READ, a);
		rd(OFS_DATA, v);
		check("pin high reads ones", v[7:0], 8'hff);
		give_verdict();
	end
endmodule
